//--- logic/sfs_pkg.sv
// package: constants, commands and carriers for the flash command sequencer
// Operation
// [R1] flash write starts program sequence with load-command
// [R2] low address byte selects flash operation
// [R3] program uses code 0x40, target bank/address
// [R4] program second command is active with row
// [R5] program third command: column, bank, write data
// [R6] never issue burst terminate after program
// [R7] flash read starts status read, code 0x70
// [R8] status load-command drives host bank and address
// [R9] status second command is active, bank and row
// [R10] status third command is read, bank and column
// [R11] capture only low eight data lines
// [R12] support cas latency one, two, three
// [R13] one idle cycle between active and access; with SFS_TRCD_CYC of 1 the code issues the access in the cycle after active
// [R14] hold host access until sequence complete
package sfs_pkg;
  localparam int unsigned SFS_ADDR_W = 32;
  localparam int unsigned SFS_DATA_W = 32;
  localparam int unsigned SFS_BA_W = 2;
  localparam int unsigned SFS_SA_W = 13;
  localparam int unsigned SFS_ROW_W = 13;
  localparam int unsigned SFS_COL_W = 9;
  localparam int unsigned SFS_STAT_W = 8;
  // host address split: column lowest above byte lane, then row, then bank
  localparam int unsigned SFS_COL_LSB = 2;
  localparam int unsigned SFS_ROW_LSB = 11;
  localparam int unsigned SFS_BA_LSB = 24;
  // flash region decode
  localparam logic [SFS_ADDR_W-1:0] SFS_REGION_BASE = 32'h0c00_0000;
  localparam logic [SFS_ADDR_W-1:0] SFS_REGION_MASK = 32'hfc00_0000;
  // load-command-register operation codes on address 7:0
  localparam logic [7:0] SFS_OP_WRITE_SETUP = 8'h40;
  localparam logic [7:0] SFS_OP_READ_STATUS = 8'h70;
  // clock and timing
  localparam int unsigned SFS_CLK_PERIOD_PS = 10000;
  localparam int unsigned SFS_TRCD_NS = 10;
  localparam int unsigned SFS_TRCD_CYC_RAW = (SFS_TRCD_NS * 1000 + SFS_CLK_PERIOD_PS - 1) / SFS_CLK_PERIOD_PS;
  localparam int unsigned SFS_TRCD_CYC = (SFS_TRCD_CYC_RAW < 1) ? 1 : SFS_TRCD_CYC_RAW;
  localparam logic [1:0] SFS_CL_RESET = 2'h3;
  localparam int unsigned SFS_CNT_W = 3;

  // sdram command code {cs_n, ras_n, cas_n, we_n}
  typedef logic [3:0] sfs_cmd_t;
  localparam sfs_cmd_t SFS_CMD_NOP = 4'h7;
  localparam sfs_cmd_t SFS_CMD_ACTIVE = 4'h3;
  localparam sfs_cmd_t SFS_CMD_READ = 4'h5;
  localparam sfs_cmd_t SFS_CMD_WRITE = 4'h4;
  localparam sfs_cmd_t SFS_CMD_LCR = 4'h0;
  localparam sfs_cmd_t SFS_CMD_DESELECT = 4'hf;

  typedef enum logic [2:0] {
    SFS_IDLE,
    SFS_LCR,
    SFS_ACT,
    SFS_GAP,
    SFS_ACCESS,
    SFS_WAIT,
    SFS_DONE
  } sfs_state_e;

  // pin bundle toward the flash
  typedef struct packed {
    sfs_cmd_t cmd;
    logic [SFS_BA_W-1:0] ba;
    logic [SFS_SA_W-1:0] sa;
    logic [SFS_DATA_W-1:0] dq;
    logic dq_oe;
  } sfs_pins_s;
endpackage

//--- logic/sfs_addr_split.sv
// module: splits a host address into bank, row and column fields
`timescale 1ns/1ps
module sfs_addr_split
  import sfs_pkg::*;
(
  input wire logic [SFS_ADDR_W-1:0] addr_in,
  input wire logic [SFS_ADDR_W-1:0] base_in,
  input wire logic [SFS_ADDR_W-1:0] mask_in,
  output logic hit_out,
  output logic [SFS_BA_W-1:0] ba_out,
  output logic [SFS_ROW_W-1:0] row_out,
  output logic [SFS_COL_W-1:0] col_out
);
  // region compare and field extraction
  assign hit_out = (addr_in & mask_in) == (base_in & mask_in);
  assign ba_out = addr_in[SFS_BA_LSB +: SFS_BA_W];
  assign row_out = addr_in[SFS_ROW_LSB +: SFS_ROW_W];
  assign col_out = addr_in[SFS_COL_LSB +: SFS_COL_W];
endmodule

//--- logic/sfs_latency_counter.sv
// module: down counter that flags when a programmed count has elapsed
`timescale 1ns/1ps
module sfs_latency_counter
  import sfs_pkg::*;
#(
  parameter int unsigned WIDTH = SFS_CNT_W
) (
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic load_in,
  input wire logic [WIDTH-1:0] count_in,
  output logic zero_out
);
  logic [WIDTH-1:0] cnt_q;
  logic [WIDTH-1:0] cnt_d;

  // load wins, otherwise count down to zero
  assign cnt_d = load_in ? count_in : ((cnt_q != '0) ? cnt_q - 1'b1 : cnt_q);
  assign zero_out = (cnt_q == '0);

  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
endmodule

//--- logic/sfs_sequencer.sv
// module: turns host accesses to the flash region into command triplets
`timescale 1ns/1ps
module sfs_sequencer
  import sfs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic [1:0] cas_latency_in,
  input wire logic host_req_in,
  input wire logic host_write_in,
  input wire logic [SFS_ADDR_W-1:0] host_addr_in,
  input wire logic [SFS_DATA_W-1:0] host_wdata_in,
  output logic host_busy_out,
  output logic host_done_out,
  output logic host_miss_out,
  output logic [SFS_DATA_W-1:0] host_rdata_out,
  input wire logic [SFS_DATA_W-1:0] flash_dq_in,
  output logic [SFS_DATA_W-1:0] flash_dq_out,
  output logic flash_dq_oe_out,
  output logic flash_cs_n_out,
  output logic flash_ras_n_out,
  output logic flash_cas_n_out,
  output logic flash_we_n_out,
  output logic [SFS_BA_W-1:0] flash_ba_out,
  output logic [SFS_SA_W-1:0] flash_sa_out
);
  sfs_state_e state_q;
  sfs_state_e state_d;
  logic write_q;
  logic [SFS_ADDR_W-1:0] addr_q;
  logic [SFS_DATA_W-1:0] wdata_q;
  logic [1:0] cl_q;
  sfs_pins_s pins_q;
  sfs_pins_s pins_d;
  logic busy_q;
  logic done_q;
  logic miss_q;
  logic [SFS_DATA_W-1:0] rdata_q;

  wire hit;
  wire [SFS_BA_W-1:0] cur_ba;
  wire [SFS_ROW_W-1:0] cur_row;
  wire [SFS_COL_W-1:0] cur_col;
  wire cnt_zero;
  wire cnt_load;
  wire [SFS_CNT_W-1:0] cnt_value;
  wire accept;
  wire capture;
  wire [SFS_CNT_W-1:0] cl_cycles;
  wire [SFS_CNT_W-1:0] gap_cycles;
  wire [SFS_ADDR_W-1:0] split_addr;

  // the new address while idle, the held one once a sequence runs
  assign split_addr = (state_q == SFS_IDLE) ? host_addr_in : addr_q;

  // decode bank, row and column of the selected address
  sfs_addr_split u_split (
    .addr_in(split_addr),
    .base_in(SFS_REGION_BASE),
    .mask_in(SFS_REGION_MASK),
    .hit_out(hit),
    .ba_out(cur_ba),
    .row_out(cur_row),
    .col_out(cur_col)
  );

  // shared counter for the active gap and the cas latency wait
  sfs_latency_counter #(
    .WIDTH(SFS_CNT_W)
  ) u_cnt (
    .core_clk_in(core_clk_in),
    .reset_in(reset_in),
    .load_in(cnt_load),
    .count_in(cnt_value),
    .zero_out(cnt_zero)
  );

  // latency counts; the wait state lasts one cycle more than the load
  assign cl_cycles = {1'b0, cl_q} - 3'h1; // [R12]
  // active state is the first cycle of the row delay, the gap state covers the rest
  assign gap_cycles = (SFS_TRCD_CYC > 1) ? (3'(SFS_TRCD_CYC) - 3'h2) : 3'h0; // [R13]
  assign cnt_load = (state_q == SFS_ACT) || (state_q == SFS_ACCESS);
  assign cnt_value = (state_q == SFS_ACT) ? gap_cycles : cl_cycles;
  assign accept = (state_q == SFS_IDLE) && host_req_in && hit; // [R1] [R7]
  assign capture = (state_q == SFS_WAIT) && cnt_zero; // [R12]

  // sequence state machine
  always_comb begin
    state_d = state_q;
    case (state_q)
      SFS_IDLE: begin
        if (accept) begin
          state_d = SFS_LCR;
        end
      end
      SFS_LCR: begin
        state_d = SFS_ACT; // [R4] [R9]
      end
      SFS_ACT: begin
        state_d = (SFS_TRCD_CYC > 1) ? SFS_GAP : SFS_ACCESS;
      end
      SFS_GAP: begin
        if (cnt_zero) begin
          state_d = SFS_ACCESS; // [R13]
        end
      end
      SFS_ACCESS: begin
        // a program write ends here with no burst terminate
        state_d = write_q ? SFS_DONE : SFS_WAIT; // [R6]
      end
      SFS_WAIT: begin
        if (cnt_zero) begin
          state_d = SFS_DONE;
        end
      end
      SFS_DONE: begin
        state_d = SFS_IDLE;
      end
      default: begin
        state_d = SFS_IDLE;
      end
    endcase
  end

  // command and pin values presented in each state, registered below
  always_comb begin
    pins_d = '{cmd: SFS_CMD_NOP, ba: '0, sa: '0, dq: '0, dq_oe: 1'b0};
    case (state_d)
      SFS_LCR: begin
        // operation code on the low byte, target address above it
        pins_d.cmd = SFS_CMD_LCR; // [R1] [R7]
        pins_d.ba = cur_ba; // [R3] [R8]
        pins_d.sa = {cur_row[SFS_SA_W-1:8], (host_write_in ? SFS_OP_WRITE_SETUP : SFS_OP_READ_STATUS)}; // [R2] [R3] [R7]
      end
      SFS_ACT: begin
        pins_d.cmd = SFS_CMD_ACTIVE; // [R4] [R9]
        pins_d.ba = cur_ba;
        pins_d.sa = cur_row;
      end
      SFS_ACCESS: begin
        pins_d.ba = cur_ba; // [R5] [R10]
        pins_d.sa = {{(SFS_SA_W-SFS_COL_W){1'b0}}, cur_col};
        if (write_q) begin
          pins_d.cmd = SFS_CMD_WRITE; // [R5]
          pins_d.dq = wdata_q;
          pins_d.dq_oe = 1'b1;
        end else begin
          pins_d.cmd = SFS_CMD_READ; // [R10]
        end
      end
      default: begin
        pins_d.cmd = SFS_CMD_NOP;
      end
    endcase
  end

  // host side latches and flash pin registers
  always_ff @(posedge core_clk_in) begin
    if (reset_in) begin
      state_q <= SFS_IDLE;
      write_q <= 1'b0;
      addr_q <= '0;
      wdata_q <= '0;
      cl_q <= SFS_CL_RESET;
      pins_q <= '{cmd: SFS_CMD_DESELECT, ba: '0, sa: '0, dq: '0, dq_oe: 1'b0};
      busy_q <= 1'b0;
      done_q <= 1'b0;
      miss_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      state_q <= state_d;
      pins_q <= pins_d;
      if (accept) begin
        write_q <= host_write_in;
        addr_q <= host_addr_in;
        wdata_q <= host_wdata_in;
        // latency is sampled per access; zero is treated as three
        cl_q <= (cas_latency_in == 2'h0) ? SFS_CL_RESET : cas_latency_in; // [R12]
      end
      busy_q <= (state_d != SFS_IDLE) && (state_d != SFS_DONE); // [R14]
      done_q <= (state_d == SFS_DONE); // [R14]
      miss_q <= (state_q == SFS_IDLE) && host_req_in && !hit;
      if (capture) begin
        rdata_q <= {{(SFS_DATA_W-SFS_STAT_W){1'b0}}, flash_dq_in[SFS_STAT_W-1:0]}; // [R11]
      end
    end
  end

  // outputs straight from flip-flops
  assign host_busy_out = busy_q;
  assign host_done_out = done_q;
  assign host_miss_out = miss_q;
  assign host_rdata_out = rdata_q;
  assign flash_cs_n_out = pins_q.cmd[3];
  assign flash_ras_n_out = pins_q.cmd[2];
  assign flash_cas_n_out = pins_q.cmd[1];
  assign flash_we_n_out = pins_q.cmd[0];
  assign flash_ba_out = pins_q.ba;
  assign flash_sa_out = pins_q.sa;
  assign flash_dq_out = pins_q.dq;
  assign flash_dq_oe_out = pins_q.dq_oe;
endmodule

//--- tb/sfs_sequencer_sva.sv
// checker: port-level timing of the flash command triplets
`timescale 1ns/1ps
module sfs_sequencer_sva
  import sfs_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic reset_in,
  input wire logic host_req_in,
  input wire logic host_write_in,
  input wire logic [SFS_ADDR_W-1:0] host_addr_in,
  input wire logic [SFS_DATA_W-1:0] host_wdata_in,
  input wire logic host_busy_out,
  input wire logic host_done_out,
  input wire logic host_miss_out,
  input wire logic [SFS_DATA_W-1:0] host_rdata_out,
  input wire logic [SFS_DATA_W-1:0] flash_dq_out,
  input wire logic flash_dq_oe_out,
  input wire logic flash_cs_n_out,
  input wire logic flash_ras_n_out,
  input wire logic flash_cas_n_out,
  input wire logic flash_we_n_out,
  input wire logic [SFS_BA_W-1:0] flash_ba_out,
  input wire logic [SFS_SA_W-1:0] flash_sa_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (reset_in);
  // command code, region hit and accept condition
  wire logic [3:0] cmd = {flash_cs_n_out, flash_ras_n_out, flash_cas_n_out, flash_we_n_out};
  wire logic hit = (host_addr_in & SFS_REGION_MASK) == SFS_REGION_BASE;
  wire logic take = host_req_in && hit && !host_busy_out && !host_done_out;
  wire logic idle_req = host_req_in && !host_busy_out && !host_done_out;
  property p_lcr;
    take |=> cmd == SFS_CMD_LCR && flash_ba_out == $past(host_addr_in[25:24]) &&
      flash_sa_out[7:0] == ($past(host_write_in) ? SFS_OP_WRITE_SETUP : SFS_OP_READ_STATUS);
  endproperty
  a_lcr: assert property (p_lcr) else $error("load command wrong");
  property p_act;
    take |=> ##1 cmd == SFS_CMD_ACTIVE && flash_sa_out == $past(host_addr_in[23:11], 2) &&
      flash_ba_out == $past(host_addr_in[25:24], 2);
  endproperty
  a_act: assert property (p_act) else $error("active command wrong");
  property p_wr;
    take && host_write_in |=> ##2 cmd == SFS_CMD_WRITE && flash_dq_oe_out &&
      flash_sa_out[8:0] == $past(host_addr_in[10:2], 3) && flash_dq_out == $past(host_wdata_in, 3);
  endproperty
  a_wr: assert property (p_wr) else $error("write command wrong");
  property p_rd;
    take && !host_write_in |=> ##2 cmd == SFS_CMD_READ && flash_sa_out[8:0] == $past(host_addr_in[10:2], 3);
  endproperty
  a_rd: assert property (p_rd) else $error("read command wrong");
  property p_nobt;
    cmd == SFS_CMD_WRITE |=> cmd == SFS_CMD_NOP && !flash_dq_oe_out;
  endproperty
  a_nobt: assert property (p_nobt) else $error("command after write wrong");
  property p_busy;
    take |=> (host_busy_out && !host_done_out) [*3];
  endproperty
  a_busy: assert property (p_busy) else $error("busy dropped early");
  property p_done;
    take |-> ##[4:9] host_done_out;
  endproperty
  a_done: assert property (p_done) else $error("done missing");
  property p_upper;
    host_done_out |-> host_rdata_out[31:8] == 24'h0;
  endproperty
  a_upper: assert property (p_upper) else $error("upper read bits set");
  property p_miss;
    idle_req && !hit |=> host_miss_out && cmd != SFS_CMD_LCR;
  endproperty
  a_miss: assert property (p_miss) else $error("miss wrong");
  c_wr: cover property (take && host_write_in);
  c_rd: cover property (take && !host_write_in);
  c_miss: cover property (host_miss_out);
endmodule

//--- tb/sfs_flash_model.sv
// model: flash part answering command triplets
`timescale 1ns/1ps
module sfs_flash_model
  import sfs_pkg::*;
(
  input wire logic clk_in,
  input wire logic [1:0] cl_in,
  input wire logic [7:0] status_in,
  input wire sfs_pins_s pins_in,
  output logic [SFS_DATA_W-1:0] dq_out,
  output sfs_pins_s lcr_q,
  output sfs_pins_s act_q,
  output sfs_pins_s acc_q
);
  logic [1:0] cnt_q = 2'h0;
  logic [23:0] noise_q = 24'h0;
  wire logic [1:0] cl = (cl_in == 2'h0) ? 2'h3 : cl_in;
  // status only at the latency edge, changing junk otherwise
  assign dq_out = {noise_q, (cnt_q == 2'h1) ? status_in : ~status_in ^ noise_q[7:0]};
  // register each command of the triplet
  always_ff @(posedge clk_in) begin
    noise_q <= noise_q + 24'h05a3c1;
    if (pins_in.cmd == SFS_CMD_LCR) lcr_q <= pins_in;
    if (pins_in.cmd == SFS_CMD_ACTIVE) act_q <= pins_in;
    if (pins_in.cmd == SFS_CMD_WRITE || pins_in.cmd == SFS_CMD_READ) acc_q <= pins_in;
    cnt_q <= (pins_in.cmd == SFS_CMD_READ) ? cl : ((cnt_q == 2'h0) ? 2'h0 : cnt_q - 2'h1);
  end
endmodule

//--- tb/tb.sv
// testbench: random and corner accesses through the flash sequencer
`timescale 1ns/1ps
bind sfs_sequencer sfs_sequencer_sva chk (.core_clk_in(core_clk_in), .reset_in(reset_in),
  .host_req_in(host_req_in), .host_write_in(host_write_in), .host_addr_in(host_addr_in),
  .host_wdata_in(host_wdata_in), .host_busy_out(host_busy_out), .host_done_out(host_done_out),
  .host_miss_out(host_miss_out), .host_rdata_out(host_rdata_out), .flash_dq_out(flash_dq_out),
  .flash_dq_oe_out(flash_dq_oe_out), .flash_cs_n_out(flash_cs_n_out), .flash_ras_n_out(flash_ras_n_out),
  .flash_cas_n_out(flash_cas_n_out), .flash_we_n_out(flash_we_n_out), .flash_ba_out(flash_ba_out),
  .flash_sa_out(flash_sa_out));
module tb;
  import sfs_pkg::*;
  logic core_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic [1:0] cas_latency_in = 2'h1;
  logic host_req_in = 1'b0;
  logic host_write_in = 1'b0;
  logic [31:0] host_addr_in = 32'h0;
  logic [31:0] host_wdata_in = 32'h0;
  logic host_busy_out, host_done_out, host_miss_out, flash_dq_oe_out;
  logic flash_cs_n_out, flash_ras_n_out, flash_cas_n_out, flash_we_n_out;
  logic [31:0] host_rdata_out, flash_dq_in, flash_dq_out, mdl_dq, r;
  logic [1:0] flash_ba_out;
  logic [12:0] flash_sa_out;
  logic [7:0] status = 8'h0;
  logic [31:0] seed = 32'h1d;
  sfs_pins_s pins, lcr, act, acc;
  int errors = 0, checks = 0, cyc = 0;
  int lat [4];
  sfs_sequencer dut (.core_clk_in(core_clk_in), .reset_in(reset_in), .cas_latency_in(cas_latency_in),
    .host_req_in(host_req_in), .host_write_in(host_write_in), .host_addr_in(host_addr_in),
    .host_wdata_in(host_wdata_in), .host_busy_out(host_busy_out), .host_done_out(host_done_out),
    .host_miss_out(host_miss_out), .host_rdata_out(host_rdata_out), .flash_dq_in(flash_dq_in),
    .flash_dq_out(flash_dq_out), .flash_dq_oe_out(flash_dq_oe_out), .flash_cs_n_out(flash_cs_n_out),
    .flash_ras_n_out(flash_ras_n_out), .flash_cas_n_out(flash_cas_n_out), .flash_we_n_out(flash_we_n_out),
    .flash_ba_out(flash_ba_out), .flash_sa_out(flash_sa_out));
  sfs_flash_model mdl (.clk_in(core_clk_in), .cl_in(cas_latency_in), .status_in(status), .pins_in(pins),
    .dq_out(mdl_dq), .lcr_q(lcr), .act_q(act), .acc_q(acc));
  // pin bundle and shared data wire
  assign pins = {flash_cs_n_out, flash_ras_n_out, flash_cas_n_out, flash_we_n_out, flash_ba_out, flash_sa_out,
    flash_dq_out, flash_dq_oe_out};
  assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : mdl_dq;
  initial begin
    forever #5 core_clk_in = ~core_clk_in;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // expected operation code, and cycles from request to a seen done pulse
  function automatic logic [31:0] exp_op(input logic w);
    return w ? 32'(SFS_OP_WRITE_SETUP) : 32'(SFS_OP_READ_STATUS);
  endfunction
  function automatic int exp_cycles(input logic w, input logic [1:0] c);
    return w ? 4 : 4 + ((c == 2'h0) ? 3 : int'(c));
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // one held access, then the triplet as the flash saw it
  task automatic access(input logic w, input logic [31:0] a, input logic [1:0] c, output int n);
    logic [31:0] d;
    d = rnd();
    n = 0;
    @(posedge core_clk_in);
    #1;
    cas_latency_in = c;
    host_write_in = w;
    host_addr_in = a;
    host_wdata_in = d;
    status = 8'(rnd());
    host_req_in = 1'b1;
    do begin
      @(posedge core_clk_in);
      #1;
      n++;
    end while (host_done_out !== 1'b1 && n < 30);
    host_req_in = 1'b0;
    check("done", 32'(host_done_out), 32'h1);
    check("cycles", 32'(n), 32'(exp_cycles(w, c)));
    check("op", 32'(lcr.sa[7:0]), exp_op(w));
    check("lcr high", 32'(lcr.sa[12:8]), 32'(a[23:19]));
    check("lcr bank", 32'(lcr.ba), 32'(a[25:24]));
    check("row", 32'(act.sa), 32'(a[23:11]));
    check("act bank", 32'(act.ba), 32'(a[25:24]));
    check("col", 32'(acc.sa[8:0]), 32'(a[10:2]));
    check("cmd", 32'(acc.cmd), w ? 32'(SFS_CMD_WRITE) : 32'(SFS_CMD_READ));
    if (w) check("wdata", acc.dq, d);
    else check("status", host_rdata_out, {24'h0, status});
  endtask
  // request outside the region is refused
  task automatic stray(input logic [31:0] a);
    @(posedge core_clk_in);
    #1;
    host_addr_in = a;
    host_req_in = 1'b1;
    repeat (2) @(posedge core_clk_in);
    #1;
    check("miss", 32'(host_miss_out), 32'h1);
    check("busy", 32'(host_busy_out), 32'h0);
    host_req_in = 1'b0;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      finish_test();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk_in);
    #1;
    reset_in = 1'b0;
    for (int i = 0; i < 4; i++) access(1'b0, {6'h03, 26'(rnd())}, 2'(i), lat[i]);
    check("cl2 delay", 32'(lat[2] - lat[1]), 32'h1);
    check("cl3 delay", 32'(lat[3] - lat[1]), 32'h2);
    check("cl0 delay", 32'(lat[0]), 32'(lat[3]));
    access(1'b1, 32'h0c00_0000, 2'h2, lat[0]);
    access(1'b1, 32'h0fff_fffc, 2'h1, lat[0]);
    stray(32'h1000_0000);
    stray(32'h0bff_fffc);
    for (int i = 0; i < 30; i++) begin
      r = rnd();
      access(r[0], {6'h03, 26'(rnd())}, r[2:1], lat[1]);
    end
    finish_test();
  end
endmodule
